/* File: rtl/fan_tach_pkg.sv */
// ************************************************************
// constants and carriers for the fan tach block
// ************************************************************
package fan_tach_pkg;

  // clock and oscillator timing
  localparam int CLK_HZ         = 50000000;
  localparam int OSC_HZ         = 11250;
  localparam int OSC_DIV_CYCLES = CLK_HZ / OSC_HZ;
  localparam int SPINUP_MS      = 2000;
  localparam int SPINUP_CYCLES  = SPINUP_MS * (CLK_HZ / 1000);

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CFG1   = 8'h00;
  localparam logic [7:0] IDX_CFG2   = 8'h01;
  localparam logic [7:0] IDX_STAT1  = 8'h02;
  localparam logic [7:0] IDX_STAT2  = 8'h03;
  localparam logic [7:0] IDX_TEST   = 8'h07;
  localparam logic [7:0] IDX_SPEED  = 8'h08;
  localparam logic [7:0] IDX_LIMIT  = 8'h10;
  localparam logic [7:0] IDX_CHAR   = 8'h20;
  localparam logic [7:0] IDX_SET    = 8'h22;
  localparam logic [7:0] IDX_FILTER = 8'h23;
  localparam logic [7:0] IDX_LRAMP  = 8'h24;
  localparam logic [7:0] IDX_RRAMP  = 8'h25;
  localparam logic [7:0] IDX_PART   = 8'h3D;
  localparam logic [7:0] IDX_MAKER  = 8'h3E;
  localparam logic [7:0] IDX_REV    = 8'h3F;

  // reset values
  localparam logic [7:0] RST_CFG1   = 8'h90;
  localparam logic [7:0] RST_CFG2   = 8'h7F;
  localparam logic [7:0] RST_SPEED  = 8'h00;
  localparam logic [7:0] RST_LIMIT  = 8'hFF;
  localparam logic [7:0] RST_CHAR   = 8'h5D;
  localparam logic [7:0] RST_SET    = 8'h55;
  localparam logic [7:0] RST_FILTER = 8'h55;
  localparam logic [7:0] RST_LRAMP  = 8'h41;
  localparam logic [7:0] RST_RRAMP  = 8'h61;

  // field positions
  localparam int CFG1_MONITOR = 0;
  localparam int CFG1_INT_EN  = 1;
  localparam int CFG1_INVERT  = 3;
  localparam int CFG1_FAULTEN = 4;
  localparam int CFG2_MEASURE = 2;
  localparam int STAT1_FAN    = 1;
  localparam int CHAR_RANGE   = 6;
  localparam int REV_LINK     = 7;

  // measurement and fault figures
  localparam logic [7:0] COUNT_MAX  = 8'hFF;
  localparam logic [2:0] FAIL_LIMIT = 3'h5;
  localparam logic [3:0] PWM_LAST   = 4'hE;

  typedef enum logic [3:0] {
    M_IDLE  = 4'h1,
    M_SYNC  = 4'h2,
    M_ARM   = 4'h4,
    M_COUNT = 4'h8
  } measState_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apbReq_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apbRsp_type;

endpackage

/* File: rtl/rate_tick.sv */
`timescale 1ns/1ps
// ************************************************************
// oscillator tick and speed range prescaler
// ************************************************************
module rate_tick
  import fan_tach_pkg::*;
#(
  parameter int BASE_DIV = OSC_DIV_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [1:0] rangeSel,
  output logic            baseTick,
  output logic            rangeTick
);
  localparam int DW = $clog2(BASE_DIV);

  logic [DW-1:0] div_q, div_d;
  logic [2:0]    pre_q, pre_d;
  logic          base_q, base_d;
  logic          rng_q, rng_d;
  logic [2:0]    rangeMask;

  // N = 1, 2, 4, 8 keeps every Nth oscillator tick
  assign rangeMask = 3'((4'h1 << rangeSel) - 4'h1);

  // next divider and prescaler state
  always_comb begin
    div_d  = div_q + DW'(1);
    pre_d  = pre_q;
    base_d = 1'b0;
    rng_d  = 1'b0;
    if (div_q == DW'(BASE_DIV - 1)) begin
      div_d  = '0;
      base_d = 1'b1;
      pre_d  = pre_q + 3'h1;
      rng_d  = ((pre_q & rangeMask) == rangeMask);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      div_q  <= '0;
      pre_q  <= 3'h0;
      base_q <= 1'b0;
      rng_q  <= 1'b0;
    end else begin
      div_q  <= div_d;
      pre_q  <= pre_d;
      base_q <= base_d;
      rng_q  <= rng_d;
    end
  end

  assign baseTick  = base_q;
  assign rangeTick = rng_q;
endmodule

/* File: rtl/rise_detect.sv */
`timescale 1ns/1ps
// ************************************************************
// rising edge detect, one lane per bit
// ************************************************************
module rise_detect #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] prev_q;

  // reset to one so a line already high at start gives no edge
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        prev_q[i] <= 1'b1;
      end else begin
        prev_q[i] <= level[i];
      end
    end
    assign rise[i] = level[i] & ~prev_q[i];
  end
endmodule

/* File: rtl/fan_tach_measure_fault.sv */
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
// ************************************************************
// fan speed measurement, limit check and fault signalling
// ************************************************************
// How it works
// - period measured by gating the oscillator tick into eight-bit counter
// - with measure bit set, each PWM drive rise restarts the measurement
// - count from second tach rise to fourth, or until overrange
// - measurement repeats while enabled; each result loads the reading
// - range bits pick divide by one, two, four or eight
// - invert bit makes the pin high for full-on drive
// - fault pin active low, open drain, enable bit set after reset
// - fault pin asserts only after five consecutive failures
// - failure only when count is strictly above the high limit
// - stalled fan reads the maximum count 0xFF unless a PWM drive rise restarts the count first
// - each failure raises the interrupt and the fan flag
// - reading status clears the interrupt output
// - each failure drives full-on for the spin-up time
// - measuring goes on while the fault pin is asserted
// - a passing result releases the fault pin, normal drive resumes
// - fixed read-only part and maker identifier registers
// - revision in low four bits, bit seven the alarm link enable
// - monitor bit enables measuring, clear after reset
// - high limit register read/write, all ones after reset
module fan_tach_measure_fault
  import fan_tach_pkg::*;
#(
  parameter int         OSC_DIV     = OSC_DIV_CYCLES,
  parameter int         SPIN_CYCLES = SPINUP_CYCLES,
  parameter logic [7:0] PART_ID     = 8'hA5, // arbitrary value
  parameter logic [7:0] MAKER_ID    = 8'h5A, // arbitrary value
  parameter logic [3:0] REVISION    = 4'h1   // arbitrary value
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire apbReq_type apbReq,
  output apbRsp_type      apbRsp,
  input  wire logic       speed_sense_in,
  output logic            pwmOut,
  output logic            intN,
  input  wire logic       faultIn,
  output logic            faultOut,
  output logic            faultOeN
);
  localparam int SW = $clog2(SPIN_CYCLES + 1);

  // ************************************************************
  // declarations
  // ************************************************************
  apbRsp_type    rsp_q, rsp_d;
  logic [7:0]    cfg1_q, cfg1_d, cfg2_q, cfg2_d;
  logic [7:0]    limit_q, limit_d, char_q, char_d;
  logic [7:0]    set_q, set_d, filter_q, filter_d;
  logic [7:0]    lramp_q, lramp_d, rramp_q, rramp_d;
  logic [7:0]    speed_q, speed_d;
  logic          link_q, link_d;
  logic          fanFlag_q, fanFlag_d, intPend_q, intPend_d;
  measState_type measState_q, measState_d;
  logic [7:0]    measCnt_q, measCnt_d;
  logic          half_q, half_d;
  logic [2:0]    failCnt_q, failCnt_d;
  logic [SW-1:0] spinCnt_q, spinCnt_d;
  logic [3:0]    pwmStep_q, pwmStep_d;
  logic          pwmOn_q, pwmOn_d;
  logic          pwmOut_q, pwmOut_d, intN_q, intN_d;
  logic          faultOeN_q, faultOeN_d, faultOut_q;
  logic [7:0]    regIdx, rdVal;
  logic          hit, access, commit, wrEn, readStat;
  logic          baseTick, rangeTick, tachRise, pwmRise;
  logic          measureOn, measDone, fail, spinning;
  logic [7:0]    measValue;

  // ************************************************************
  // helpers
  // ************************************************************
  rate_tick #(
    .BASE_DIV (OSC_DIV)
  ) u_rate (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .rangeSel  (char_q[CHAR_RANGE +: 2]),
    .baseTick  (baseTick),
    .rangeTick (rangeTick)
  );

  rise_detect #(
    .WIDTH (2)
  ) u_rise (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .level   ({pwmOn_q, speed_sense_in}),
    .rise    ({pwmRise, tachRise})
  );

  // ************************************************************
  // register bus
  // ************************************************************
  // one wait state: pready follows the first access cycle
  assign regIdx   = {2'b00, apbReq.paddr[7:2]};
  assign access   = apbReq.psel & apbReq.penable & ~rsp_q.pready;
  assign commit   = apbReq.psel & apbReq.penable & rsp_q.pready;
  assign wrEn     = commit & apbReq.pwrite & ~rsp_q.pslverr;
  assign readStat = commit & ~apbReq.pwrite & ~rsp_q.pslverr &
                    (regIdx == IDX_STAT1 || regIdx == IDX_STAT2);

  // read mux; the factory test slot reads zero and ignores writes
  always_comb begin
    rdVal = 8'h00;
    hit   = 1'b1;
    case (regIdx)
      IDX_CFG1:   rdVal = cfg1_q;
      IDX_CFG2:   rdVal = cfg2_q;
      IDX_STAT1:  rdVal = {6'h00, fanFlag_q, 1'b0};
      IDX_STAT2:  rdVal = 8'h00;
      IDX_TEST:   rdVal = 8'h00;
      IDX_SPEED:  rdVal = speed_q;
      IDX_LIMIT:  rdVal = limit_q;
      IDX_CHAR:   rdVal = char_q;
      IDX_SET:    rdVal = set_q;
      IDX_FILTER: rdVal = filter_q;
      IDX_LRAMP:  rdVal = lramp_q;
      IDX_RRAMP:  rdVal = rramp_q;
      IDX_PART:   rdVal = PART_ID;
      IDX_MAKER:  rdVal = MAKER_ID;
      IDX_REV:    rdVal = {link_q, 3'b000, REVISION};
      default:    hit = 1'b0;
    endcase
    if (apbReq.paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end
  end

  // answer latched in the access cycle, held until the next one
  always_comb begin
    rsp_d        = rsp_q;
    rsp_d.pready = access;
    if (access) begin
      rsp_d.prdata  = {24'h000000, rdVal};
      rsp_d.pslverr = ~hit;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // ************************************************************
  // software registers
  // ************************************************************
  // a finished measurement beats a software write of the reading
  always_comb begin
    cfg1_d   = cfg1_q;
    cfg2_d   = cfg2_q;
    limit_d  = limit_q;
    char_d   = char_q;
    set_d    = set_q;
    filter_d = filter_q;
    lramp_d  = lramp_q;
    rramp_d  = rramp_q;
    link_d   = link_q;
    speed_d  = speed_q;
    if (wrEn) begin
      case (regIdx)
        IDX_CFG1:   cfg1_d   = apbReq.pwdata[7:0];
        IDX_CFG2:   cfg2_d   = apbReq.pwdata[7:0];
        IDX_SPEED:  speed_d  = apbReq.pwdata[7:0];
        IDX_LIMIT:  limit_d  = apbReq.pwdata[7:0];
        IDX_CHAR:   char_d   = apbReq.pwdata[7:0];
        IDX_SET:    set_d    = apbReq.pwdata[7:0];
        IDX_FILTER: filter_d = apbReq.pwdata[7:0];
        IDX_LRAMP:  lramp_d  = apbReq.pwdata[7:0];
        IDX_RRAMP:  rramp_d  = apbReq.pwdata[7:0];
        IDX_REV:    link_d   = apbReq.pwdata[REV_LINK];
        default:    link_d   = link_q;
      endcase
    end
    if (measDone) begin
      speed_d = measValue;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg1_q   <= RST_CFG1;
      cfg2_q   <= RST_CFG2;
      limit_q  <= RST_LIMIT;
      char_q   <= RST_CHAR;
      set_q    <= RST_SET;
      filter_q <= RST_FILTER;
      lramp_q  <= RST_LRAMP;
      rramp_q  <= RST_RRAMP;
      link_q   <= 1'b0;
      speed_q  <= RST_SPEED;
    end else begin
      cfg1_q   <= cfg1_d;
      cfg2_q   <= cfg2_d;
      limit_q  <= limit_d;
      char_q   <= char_d;
      set_q    <= set_d;
      filter_q <= filter_d;
      lramp_q  <= lramp_d;
      rramp_q  <= rramp_d;
      link_q   <= link_d;
      speed_q  <= speed_d;
    end
  end

  // ************************************************************
  // period measurement
  // ************************************************************
  assign measureOn = cfg1_q[CFG1_MONITOR] & cfg2_q[CFG2_MEASURE];

  // overrange is checked before the tach edges, so a stall ends a cycle unless a PWM drive rise restarts it first
  always_comb begin
    measState_d = measState_q;
    measCnt_d   = measCnt_q;
    half_d      = half_q;
    measDone    = 1'b0;
    measValue   = measCnt_q;
    if (!measureOn) begin
      measState_d = M_IDLE;
    end else if (pwmRise || measState_q == M_IDLE) begin
      measState_d = M_SYNC;
      measCnt_d   = 8'h00;
      half_d      = 1'b0;
    end else if (rangeTick && measCnt_q == COUNT_MAX) begin
      measDone    = 1'b1;
      measValue   = COUNT_MAX;
      measState_d = M_SYNC;
      measCnt_d   = 8'h00;
      half_d      = 1'b0;
    end else begin
      if (rangeTick) begin
        measCnt_d = measCnt_q + 8'h01;
      end
      case (measState_q)
        M_SYNC: begin
          if (tachRise) begin
            measState_d = M_ARM;
          end
        end
        M_ARM: begin
          if (tachRise) begin
            measState_d = M_COUNT;
            measCnt_d   = 8'h00;
          end
        end
        M_COUNT: begin
          if (tachRise && half_q) begin
            measDone    = 1'b1;
            measState_d = M_SYNC;
            measCnt_d   = 8'h00;
            half_d      = 1'b0;
          end else if (tachRise) begin
            half_d = 1'b1;
          end
        end
        default: measState_d = M_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      measState_q <= M_IDLE;
      measCnt_q   <= 8'h00;
      half_q      <= 1'b0;
    end else begin
      measState_q <= measState_d;
      measCnt_q   <= measCnt_d;
      half_q      <= half_d;
    end
  end

  // ************************************************************
  // failure handling and drive
  // ************************************************************
  // measuring never stops on a fault, so flags keep rising
  assign fail     = measDone && (measValue > limit_q);
  assign spinning = (spinCnt_q != '0);

  always_comb begin
    failCnt_d = failCnt_q;
    if (measDone && fail && failCnt_q != FAIL_LIMIT) begin
      failCnt_d = failCnt_q + 3'h1;
    end else if (measDone && !fail) begin
      failCnt_d = 3'h0;
    end
    spinCnt_d = spinning ? spinCnt_q - SW'(1) : spinCnt_q;
    if (fail) begin
      spinCnt_d = SW'(SPIN_CYCLES);
    end
    // set wins over the read that clears
    fanFlag_d = fail | (fanFlag_q & ~(readStat &&
                regIdx == IDX_STAT1));
    intPend_d = fail | (intPend_q & ~readStat);
    // pwm steps through fifteen slots on the base oscillator tick
    pwmStep_d = pwmStep_q;
    if (baseTick) begin
      pwmStep_d = (pwmStep_q == PWM_LAST) ? 4'h0 : pwmStep_q + 4'h1;
    end
    pwmOn_d    = spinning | (pwmStep_q < set_q[3:0]);
    pwmOut_d   = cfg1_q[CFG1_INVERT] ? pwmOn_q : ~pwmOn_q;
    intN_d     = ~(intPend_q & cfg1_q[CFG1_INT_EN]);
    faultOeN_d = ~((failCnt_q == FAIL_LIMIT) &
                 cfg1_q[CFG1_FAULTEN]);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      failCnt_q  <= 3'h0;
      spinCnt_q  <= '0;
      fanFlag_q  <= 1'b0;
      intPend_q  <= 1'b0;
      pwmStep_q  <= 4'h0;
      pwmOn_q    <= 1'b0;
      pwmOut_q   <= 1'b1;
      intN_q     <= 1'b1;
      faultOeN_q <= 1'b1;
      faultOut_q <= 1'b0;
    end else begin
      failCnt_q  <= failCnt_d;
      spinCnt_q  <= spinCnt_d;
      fanFlag_q  <= fanFlag_d;
      intPend_q  <= intPend_d;
      pwmStep_q  <= pwmStep_d;
      pwmOn_q    <= pwmOn_d;
      pwmOut_q   <= pwmOut_d;
      intN_q     <= intN_d;
      faultOeN_q <= faultOeN_d;
      faultOut_q <= 1'b0; // open drain only ever pulls low
    end
  end

  assign apbRsp   = rsp_q;
  assign pwmOut   = pwmOut_q;
  assign intN     = intN_q;
  assign faultOut = faultOut_q;
  assign faultOeN = faultOeN_q;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence ackRead;
    readStat ##0 !fail;
  endsequence

  chk_fail_flag: assert property (fail |=> fanFlag_q ##1 !intN_q ||
    !cfg1_q[CFG1_INT_EN]) else $error("fan flag not raised");
  chk_int_clear: assert property (ackRead ##1 !fail |=> intN_q)
    else $error("interrupt not cleared by read");
  chk_reading_load: assert property (measDone |=>
    speed_q == $past(measValue)) else $error("reading missed");
  chk_limit_strict: assert property (measDone && measValue <= limit_q
    |=> failCnt_q == 3'h0) else $error("pass counted as fail");
  chk_fault_late: assert property ($fell(faultOeN_q) |->
    $past(failCnt_q) == FAIL_LIMIT) else $error("early fault");
  chk_spin_drive: assert property (fail |=> spinning ##2
    pwmOut_q == cfg1_q[CFG1_INVERT]) else $error("no spin-up");
  chk_monitor_off: assert property (!measureOn |=> measState_q == M_IDLE)
    else $error("measuring while disabled");
  chk_restart_pwm: assert property (pwmRise && measureOn |=>
    measState_q == M_SYNC && measCnt_q == 8'h00)
    else $error("no restart on pwm rise");
  chk_stall_max: assert property (measState_q != M_IDLE && measureOn &&
    !pwmRise && rangeTick && measCnt_q == COUNT_MAX |=>
    speed_q == COUNT_MAX) else $error("stall not saturated");
endmodule

/* File: tb/fan_model.sv */
`timescale 1ns/1ps
// ************************************************************
// behavioural fan: tach square wave, held low while stalled
// ************************************************************
module fan_model (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       stall,
  input  wire logic [7:0] halfPeriod,
  output logic            tach
);
  logic [7:0] cnt_q;

  // a stalled rotor gives no edges, so the line rests low, not at old level
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 8'h00;
      tach  <= 1'b0;
    end else if (stall) begin
      cnt_q <= 8'h00;
      tach  <= 1'b0;
    end else if (cnt_q == halfPeriod - 8'h01) begin
      cnt_q <= 8'h00;
      tach  <= ~tach;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

/* File: tb/fan_tach_measure_fault_tb_top.sv */
`timescale 1ns/1ps
// ************************************************************
// testbench top for the fan tach block
// ************************************************************
module fan_tach_measure_fault_tb_top import fan_tach_pkg::*;;
  localparam int         DIV  = 8;
  localparam int         SPIN = 50;
  localparam logic [7:0] PID  = 8'hC3; // arbitrary value
  localparam logic [7:0] MID  = 8'h3C; // arbitrary value
  localparam logic [7:0] ADDR [14] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20,
    8'h40, 8'h80, 8'h88, 8'h8C, 8'h90, 8'h94, 8'hF4, 8'hF8, 8'hFC};
  localparam logic [7:0] RSTV [14] = '{8'h90, 8'h7F, 8'h00, 8'h00, 8'h00,
    8'hFF, 8'h5D, 8'h55, 8'h55, 8'h41, 8'h61, PID, MID, 8'h02};

  logic       clk_sys;
  logic       sys_rst;
  apbReq_type apbReq;
  apbRsp_type apbRsp;
  logic       tach;
  logic       pwmOut;
  logic       intN;
  logic       faultOut;
  logic       faultOeN;
  logic       faultIn;
  logic       stall;
  logic [7:0] rdv;
  logic       err;
  int         errors;
  int         checks_done;

  // open-drain fault line with its pull-up
  assign faultIn = faultOeN ? 1'b1 : faultOut;

  fan_tach_measure_fault #(
    .OSC_DIV     (DIV),
    .SPIN_CYCLES (SPIN),
    .PART_ID     (PID),
    .MAKER_ID    (MID),
    .REVISION    (4'h2)
  ) i_dut (
    .clk_sys        (clk_sys),
    .sys_rst        (sys_rst),
    .apbReq         (apbReq),
    .apbRsp         (apbRsp),
    .speed_sense_in (tach),
    .pwmOut         (pwmOut),
    .intN           (intN),
    .faultIn        (faultIn),
    .faultOut       (faultOut),
    .faultOeN       (faultOeN)
  );

  fan_model i_fan (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .stall      (stall),
    .halfPeriod (8'h20),
    .tach       (tach)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ************************************************************
  // report, compare and bus tasks
  // ************************************************************
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic bail();
    errors++;
    $display("ERROR %0t: wait ran out", $time);
    give_verdict();
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // tick phase against tach edges leaves one count of slack
  task automatic chkNear(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if ($isunknown(got) || got > exp + 8'h01 || got + 8'h01 < exp) begin
      errors++;
      $display("ERROR %0t: got %h near %h", $time, got, exp);
    end
  endtask

  // holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] wd, output logic [7:0] rd,
                     output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    apbReq <= '{1'b1, 1'b0, wr, a, {24'h0, wd}};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 20);
    if (n >= 20) bail();
    rd = apbRsp.prdata[7:0];
    e = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, rdv, err);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00, rdv, err);
    chk8(rdv, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // reads the speed count until it equals v (eq) or differs from it
  task automatic poll(input logic eq, input logic [7:0] v);
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h20, 8'h00, rdv, err);
      n++;
    end while (((rdv === v) !== eq) && n < 1000);
    if (n >= 1000) bail();
  endtask

  task automatic waitInt();
    int n;
    n = 0;
    while (intN !== 1'b0 && n < 6000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 6000) bail();
  endtask

  // ************************************************************
  // main sequence; factory test word at 0x1C is never touched
  // ************************************************************
  initial begin
    sys_rst = 1'b1;
    apbReq = '0;
    stall = 1'b0;
    errors = 0;
    checks_done = 0;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 14; i++) begin
      rd(ADDR[i], RSTV[i]);
    end
    wr(8'h40, 8'h77);
    rd(8'h40, 8'h77);
    wr(8'hF4, 8'h00);
    rd(8'hF4, PID);
    wr(8'hFC, 8'h80);
    rd(8'hFC, 8'h82);
    apb(1'b0, 8'h14, 8'h00, rdv, err);
    chk8({7'h0, err}, 8'h01);
    apb(1'b1, 8'h41, 8'h00, rdv, err);
    chk8({7'h0, err}, 8'h01);
    rd(8'h40, 8'h77);
    // full duty keeps the drive on, so no restart cuts a measurement
    wr(8'h88, 8'h0F);
    wr(8'h00, 8'h19);
    cyc(20);
    chk8({7'h0, pwmOut}, 8'h01);
    for (int r = 0; r < 4; r++) begin
      wr(8'h80, {r[1:0], 6'h1D});
      wr(8'h20, 8'h00);
      poll(1'b0, 8'h00);
      wr(8'h20, 8'h00);
      poll(1'b0, 8'h00);
      chkNear(rdv, 8'(128 / (DIV << r)));
    end
    wr(8'h00, 8'h11);
    cyc(20);
    chk8({7'h0, pwmOut}, 8'h00);
    // stalled fan against the default all-ones limit
    wr(8'h40, 8'hFF);
    wr(8'h88, 8'h00);
    wr(8'h80, 8'h1D);
    wr(8'h00, 8'h13);
    stall <= 1'b1;
    poll(1'b1, 8'hFF);
    chk8({7'h0, intN}, 8'h01);
    rd(8'h08, 8'h00);
    wr(8'h40, 8'hFE);
    for (int k = 1; k < 10; k++) begin
      if (k == 4) begin
        stall <= 1'b0;
        poll(1'b0, 8'hFF);
        stall <= 1'b1;
      end
      waitInt();
      cyc(3);
      chk8({7'h0, pwmOut}, 8'h00);
      chk8({7'h0, faultIn}, {7'h0, k < 8});
      rd(8'h08, 8'h02);
      cyc(2);
      chk8({7'h0, intN}, 8'h01);
      rd(8'h08, 8'h00);
      if (k == 1) begin
        cyc(SPIN);
        chk8({7'h0, pwmOut}, 8'h01);
      end
    end
    // fault enable gates the asserted pin without losing the run count
    wr(8'h00, 8'h03);
    cyc(2);
    chk8({7'h0, faultIn}, 8'h01);
    wr(8'h00, 8'h13);
    cyc(2);
    chk8({7'h0, faultIn}, 8'h00);
    stall <= 1'b0;
    poll(1'b0, 8'hFF);
    cyc(4);
    chk8({7'h0, faultIn}, 8'h01);
    chk8({7'h0, pwmOut}, 8'h01);
    give_verdict();
  end
endmodule
